/* common/tct_pkg.sv */
// Shared constants, carrier types and helpers of the counter timer port
package tct_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int COUNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_CNT = 3;
	localparam int DIGIT_W = 4;
	localparam int DIGITS = COUNT_W / DIGIT_W;

	// ------------------------------------------------------------------
	// Port offsets and control word codes
	// ------------------------------------------------------------------
	localparam logic [1:0] OFS_CNT0 = 2'h0;
	localparam logic [1:0] OFS_CNT1 = 2'h1;
	localparam logic [1:0] OFS_CNT2 = 2'h2;
	localparam logic [1:0] OFS_CTRL = 2'h3;
	localparam logic [1:0] SEL_ILLEGAL = 2'h3;
	localparam logic [1:0] FMT_LATCH = 2'h0;
	localparam logic [1:0] FMT_LOW = 2'h1;
	localparam logic [1:0] FMT_HIGH = 2'h2;
	localparam logic [1:0] FMT_BOTH = 2'h3;

	// ------------------------------------------------------------------
	// Values
	// ------------------------------------------------------------------
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
	localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
	localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_TC_IRQ,
		MODE_ONE_SHOT,
		MODE_RATE,
		MODE_SQUARE,
		MODE_SW_STROBE,
		MODE_HW_STROBE
	} mode_type;

	typedef struct packed {
		logic counter_select_high;
		logic counter_select_low;
		logic access_format_high;
		logic access_format_low;
		logic mode_field_top;
		logic mode_field_middle;
		logic mode_field_bottom;
		logic bcd;
	} ctrl_word_type;

	typedef struct packed {
		mode_type mode;
		logic bcd;
		logic arm;
		logic load;
		logic [COUNT_W-1:0] value;
	} unit_ctl_type;

	typedef struct packed {
		logic [1:0] fmt;
		logic wr_high_next;
		logic rd_high_next;
		logic latched;
		logic [COUNT_W-1:0] latch_val;
		logic [BYTE_W-1:0] low_hold;
	} chan_type;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [1:0] addr;
		logic [BYTE_W-1:0] data;
		logic [NUM_CNT-1:0] cnt_clk;
		logic [NUM_CNT-1:0] gate;
		logic sixth;
		logic twelfth;
		logic ext_irq;
	} pin_type;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic mode_type decode_mode(input ctrl_word_type cw);
		mode_type m;
		if (cw.mode_field_middle) begin
			m = cw.mode_field_bottom ? MODE_SQUARE : MODE_RATE;
		end else if (cw.mode_field_top) begin
			m = cw.mode_field_bottom ? MODE_HW_STROBE : MODE_SW_STROBE;
		end else begin
			m = cw.mode_field_bottom ? MODE_ONE_SHOT : MODE_TC_IRQ;
		end
		return m;
	endfunction : decode_mode

	// Binary wraps 0 to all ones; decimal wraps 0 to 9999
	function automatic logic [COUNT_W-1:0] count_down(
		input logic [COUNT_W-1:0] v,
		input logic bcd
	);
		logic [COUNT_W-1:0] r;
		logic borrow;
		r = v - COUNT_ONE;
		borrow = 1'b1;
		if (bcd) begin
			r = v;
			for (int i = 0; i < DIGITS; i++) begin
				if (borrow) begin
					if (v[i*DIGIT_W +: DIGIT_W] == DIGIT_ZERO) begin
						r[i*DIGIT_W +: DIGIT_W] = DIGIT_MAX;
					end else begin
						r[i*DIGIT_W +: DIGIT_W] = v[i*DIGIT_W +: DIGIT_W] - DIGIT_ONE;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction : count_down

endpackage : tct_pkg

/* rtl/count_unit.sv */
// One down counter with its mode sequencing and output level
`timescale 1ns/1ps
module count_unit (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Control from the port logic
	input wire tct_pkg::unit_ctl_type ctl,
	// Synchronised counter pins
	input wire logic clk_lvl,
	input wire logic gate_lvl,
	// Results
	output logic [tct_pkg::COUNT_W-1:0] count,
	output logic out
);

	typedef struct packed {
		logic [tct_pkg::COUNT_W-1:0] count;
		logic [tct_pkg::COUNT_W-1:0] reload;
		logic out;
		logic loaded;
		logic running;
		logic trig;
		logic clk_prev;
		logic gate_prev;
	} unit_state_type;

	unit_state_type s_r;
	unit_state_type s_nxt;
	logic cnt_edge;
	logic gate_rise;
	logic edge_trig;
	logic [tct_pkg::COUNT_W-1:0] nxt;

	// Falling edge of the counting clock; 5 MHz leaves 5 samples a period
	assign cnt_edge = s_r.clk_prev && !clk_lvl;
	assign gate_rise = gate_lvl && !s_r.gate_prev;
	assign edge_trig = (ctl.mode == tct_pkg::MODE_ONE_SHOT) ||
		(ctl.mode == tct_pkg::MODE_HW_STROBE);
	assign nxt = tct_pkg::count_down(s_r.count, ctl.bcd);

	always_comb begin
		s_nxt = s_r;
		s_nxt.clk_prev = clk_lvl;
		s_nxt.gate_prev = gate_lvl;
		if (ctl.arm) begin
			s_nxt.out = ctl.mode != tct_pkg::MODE_TC_IRQ;
			s_nxt.loaded = 1'b0;
			s_nxt.running = 1'b0;
			s_nxt.trig = 1'b0;
		end else if (ctl.load) begin
			s_nxt.reload = ctl.value;
			s_nxt.count = ctl.value;
			s_nxt.loaded = 1'b1;
			s_nxt.running = !edge_trig;
			s_nxt.trig = 1'b0;
			if (ctl.mode == tct_pkg::MODE_TC_IRQ) begin
				s_nxt.out = 1'b0;
			end
		end else begin
			if (gate_rise && edge_trig && s_r.loaded) begin
				s_nxt.trig = 1'b1;
			end
			if (cnt_edge && s_r.trig) begin
				s_nxt.count = s_r.reload;
				s_nxt.trig = 1'b0;
				s_nxt.running = 1'b1;
				if (ctl.mode == tct_pkg::MODE_ONE_SHOT) begin
					s_nxt.out = 1'b0;
				end
			end else if (cnt_edge && s_r.running && (edge_trig || gate_lvl)) begin
				s_nxt.count = nxt;
				case (ctl.mode)
					tct_pkg::MODE_TC_IRQ, tct_pkg::MODE_ONE_SHOT: begin
						if (nxt == tct_pkg::COUNT_ZERO) begin
							s_nxt.out = 1'b1;
						end
					end
					tct_pkg::MODE_RATE: begin
						if (s_r.count == tct_pkg::COUNT_ONE) begin
							s_nxt.count = s_r.reload;
							s_nxt.out = 1'b1;
						end else if (nxt == tct_pkg::COUNT_ONE) begin
							s_nxt.out = 1'b0;
						end
					end
					tct_pkg::MODE_SQUARE: begin
						if (s_r.count == tct_pkg::COUNT_ONE) begin
							s_nxt.count = s_r.reload;
							s_nxt.out = !s_r.out;
						end
					end
					default: begin
						s_nxt.out = nxt != tct_pkg::COUNT_ZERO;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.count;
	assign out = s_r.out;

	a_count_step: assert property (
		@(posedge core_clk) disable iff (!resetn)
		cnt_edge && s_r.running && gate_lvl && !s_r.trig && !ctl.arm &&
		!ctl.load && ctl.mode == tct_pkg::MODE_TC_IRQ
		|=> s_r.count == tct_pkg::count_down($past(s_r.count), ctl.bcd))
		else $error("Counter did not step down by one");

	a_gate_stops: assert property (
		@(posedge core_clk) disable iff (!resetn)
		cnt_edge && !gate_lvl && !s_r.trig && !ctl.arm && !ctl.load &&
		ctl.mode == tct_pkg::MODE_TC_IRQ
		|=> $stable(s_r.count))
		else $error("Counter moved while gate was low");

endmodule : count_unit

/* rtl/triple_counter_timer_port.sv */
// Three counter timer block behind a byte wide host port
// Overview of operation
// - Three independent 16-bit counters each count on their own clock.
// - Each counter takes one of six modes from its own control word.
// - Offsets 0 to 2 reach counters 0 to 2 and offset 3 the control word.
// - The block answers the host only while its chip select is active.
// - Control bits 7 and 6 select the counter and code 11 is illegal.
// - Control bits 5 and 4 pick latch, low only, high only or both bytes.
// - A latch command freezes a copy of the count for stable reads.
// - Two byte transfers move the low byte first and then the high byte.
// - Control bits 3 to 1 give the mode, top bit ignored for 2 and 3.
// - Modes are terminal count, one-shot, rate, square, soft and hard strobe.
// - Control bit 0 chooses binary or four digit decimal counting.
// - Counts wrap at 65535 in binary and at 9999 in decimal.
// - Counting clocks may run from standstill up to 5 MHz.
// - High request is the inverted sixth counter output, low is twelfth or external.
`timescale 1ns/1ps
module triple_counter_timer_port (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Host byte port
	input wire logic chip_sel_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic [1:0] port_addr,
	input wire logic [tct_pkg::BYTE_W-1:0] data_in,
	output logic [tct_pkg::BYTE_W-1:0] data_out,
	output logic data_oe,
	// Counter pins
	input wire logic [tct_pkg::NUM_CNT-1:0] count_clk,
	input wire logic [tct_pkg::NUM_CNT-1:0] count_gate,
	output logic [tct_pkg::NUM_CNT-1:0] count_out,
	// Interrupt request pins
	input wire logic sixth_counter_output,
	input wire logic twelfth_counter_output,
	input wire logic ext_irq_in,
	output logic irq_high,
	output logic irq_low
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		tct_pkg::pin_type meta;
		tct_pkg::pin_type sync;
		tct_pkg::pin_type prev;
		tct_pkg::chan_type [tct_pkg::NUM_CNT-1:0] ch;
		tct_pkg::unit_ctl_type [tct_pkg::NUM_CNT-1:0] ctl;
		logic [tct_pkg::BYTE_W-1:0] rdata;
		logic data_oe;
		logic irq_high;
		logic irq_low;
	} top_state_type;

	localparam tct_pkg::pin_type PIN_IDLE = '{
		cs_n: 1'b1,
		rd_n: 1'b1,
		wr_n: 1'b1,
		default: '0
	};
	localparam logic [tct_pkg::NUM_CNT-1:0] ARM_ONE = 3'h1;

	top_state_type s_r;
	top_state_type s_nxt;
	tct_pkg::pin_type pin_now;
	tct_pkg::ctrl_word_type cw;
	logic [tct_pkg::NUM_CNT-1:0][tct_pkg::COUNT_W-1:0] live;
	logic [tct_pkg::NUM_CNT-1:0] unit_out;
	logic [tct_pkg::NUM_CNT-1:0] arm_vec;
	logic [tct_pkg::NUM_CNT-1:0] load_vec;
	logic wr_done;
	logic rd_start;
	logic [1:0] wr_idx;
	logic [1:0] rd_idx;
	logic [1:0] wr_sel;
	logic [1:0] wr_fmt;
	logic [tct_pkg::COUNT_W-1:0] rd_val;
	logic [tct_pkg::COUNT_W-1:0] latch_src;
	logic [tct_pkg::BYTE_W-1:0] rd_lo;
	logic [tct_pkg::BYTE_W-1:0] rd_hi;

	// ------------------------------------------------------------------
	// Pin gathering and strobe decode
	// ------------------------------------------------------------------
	always_comb begin
		pin_now.cs_n = chip_sel_n;
		pin_now.rd_n = read_n;
		pin_now.wr_n = write_n;
		pin_now.addr = port_addr;
		pin_now.data = data_in;
		pin_now.cnt_clk = count_clk;
		pin_now.gate = count_gate;
		pin_now.sixth = sixth_counter_output;
		pin_now.twelfth = twelfth_counter_output;
		pin_now.ext_irq = ext_irq_in;
	end

	// Write taken at the rising strobe, with address and data of the
	// cycle before, so a host hold of zero after the strobe is enough
	assign wr_done = s_r.sync.wr_n && !s_r.prev.wr_n && !s_r.prev.cs_n;
	assign wr_idx = s_r.prev.addr;
	assign cw = tct_pkg::ctrl_word_type'(s_r.prev.data);
	assign wr_sel = {cw.counter_select_high, cw.counter_select_low};
	assign wr_fmt = {cw.access_format_high, cw.access_format_low};

	// Read taken at the falling strobe
	assign rd_start = !s_r.sync.rd_n && s_r.prev.rd_n && !s_r.sync.cs_n;
	assign rd_idx = s_r.sync.addr;
	assign rd_val = s_r.ch[rd_idx].latched ? s_r.ch[rd_idx].latch_val :
		live[rd_idx];
	assign rd_lo = rd_val[tct_pkg::BYTE_W-1:0];
	assign rd_hi = rd_val[tct_pkg::COUNT_W-1:tct_pkg::BYTE_W];
	assign latch_src = live[wr_sel];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = pin_now;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
		s_nxt.irq_high = !s_r.sync.sixth;
		s_nxt.irq_low = s_r.sync.twelfth || s_r.sync.ext_irq;
		s_nxt.data_oe = !s_r.sync.cs_n && !s_r.sync.rd_n &&
			(s_r.sync.addr != tct_pkg::OFS_CTRL);
		for (int k = 0; k < tct_pkg::NUM_CNT; k++) begin
			s_nxt.ctl[k].arm = 1'b0;
			s_nxt.ctl[k].load = 1'b0;
		end

		if (wr_done && (wr_idx == tct_pkg::OFS_CTRL)) begin
			if (wr_sel != tct_pkg::SEL_ILLEGAL) begin
				if (wr_fmt == tct_pkg::FMT_LATCH) begin
					// A second latch before the copy is read is ignored
					if (!s_r.ch[wr_sel].latched) begin
						s_nxt.ch[wr_sel].latched = 1'b1;
						s_nxt.ch[wr_sel].latch_val = latch_src;
					end
				end else begin
					s_nxt.ch[wr_sel].fmt = wr_fmt;
					s_nxt.ch[wr_sel].wr_high_next = 1'b0;
					s_nxt.ch[wr_sel].rd_high_next = 1'b0;
					s_nxt.ch[wr_sel].latched = 1'b0;
					s_nxt.ctl[wr_sel].mode = tct_pkg::decode_mode(cw);
					s_nxt.ctl[wr_sel].bcd = cw.bcd;
					s_nxt.ctl[wr_sel].arm = 1'b1;
				end
			end
		end else if (wr_done) begin
			// Until a control word arrives the format is latch and loads drop
			case (s_r.ch[wr_idx].fmt)
				tct_pkg::FMT_LOW: begin
					s_nxt.ctl[wr_idx].value = {tct_pkg::BYTE_ZERO, s_r.prev.data};
					s_nxt.ctl[wr_idx].load = 1'b1;
				end
				tct_pkg::FMT_HIGH: begin
					s_nxt.ctl[wr_idx].value = {s_r.prev.data, tct_pkg::BYTE_ZERO};
					s_nxt.ctl[wr_idx].load = 1'b1;
				end
				tct_pkg::FMT_BOTH: begin
					if (!s_r.ch[wr_idx].wr_high_next) begin
						s_nxt.ch[wr_idx].low_hold = s_r.prev.data;
						s_nxt.ch[wr_idx].wr_high_next = 1'b1;
					end else begin
						s_nxt.ctl[wr_idx].value = {s_r.prev.data,
							s_r.ch[wr_idx].low_hold};
						s_nxt.ctl[wr_idx].load = 1'b1;
						s_nxt.ch[wr_idx].wr_high_next = 1'b0;
					end
				end
				default: begin
					s_nxt.ctl[wr_idx].load = 1'b0;
				end
			endcase
		end

		if (rd_start && (rd_idx != tct_pkg::OFS_CTRL)) begin
			case (s_r.ch[rd_idx].fmt)
				tct_pkg::FMT_LOW: begin
					s_nxt.rdata = rd_lo;
					s_nxt.ch[rd_idx].latched = 1'b0;
				end
				tct_pkg::FMT_HIGH: begin
					s_nxt.rdata = rd_hi;
					s_nxt.ch[rd_idx].latched = 1'b0;
				end
				tct_pkg::FMT_BOTH: begin
					s_nxt.rdata = s_r.ch[rd_idx].rd_high_next ? rd_hi : rd_lo;
					s_nxt.ch[rd_idx].rd_high_next = !s_r.ch[rd_idx].rd_high_next;
					if (s_r.ch[rd_idx].rd_high_next) begin
						s_nxt.ch[rd_idx].latched = 1'b0;
					end
				end
				default: begin
					s_nxt.rdata = tct_pkg::BYTE_ZERO;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Strobes reset high so no false edge is seen after release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.meta <= PIN_IDLE;
			s_r.sync <= PIN_IDLE;
			s_r.prev <= PIN_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------
	for (genvar g = 0; g < tct_pkg::NUM_CNT; g++) begin : g_unit
		count_unit count_unit_i (
			.core_clk(core_clk),
			.resetn(resetn),
			.ctl(s_r.ctl[g]),
			.clk_lvl(s_r.sync.cnt_clk[g]),
			.gate_lvl(s_r.sync.gate[g]),
			.count(live[g]),
			.out(unit_out[g])
		);
		assign arm_vec[g] = s_r.ctl[g].arm;
		assign load_vec[g] = s_r.ctl[g].load;
	end

	assign data_out = s_r.rdata;
	assign data_oe = s_r.data_oe;
	assign count_out = unit_out;
	assign irq_high = s_r.irq_high;
	assign irq_low = s_r.irq_low;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_illegal_word_ignored: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel == tct_pkg::SEL_ILLEGAL
		|=> $stable(s_r.ch) && arm_vec == '0)
		else $error("Illegal select word changed a counter");

	a_ctrl_no_load: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL
		|=> load_vec == '0)
		else $error("Control port write loaded a counter");

	a_select_arms: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel != tct_pkg::SEL_ILLEGAL && wr_fmt != tct_pkg::FMT_LATCH
		|=> arm_vec == (ARM_ONE << $past(wr_sel)))
		else $error("Wrong counter took the control word");

	a_mode_decoded: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel != tct_pkg::SEL_ILLEGAL && wr_fmt != tct_pkg::FMT_LATCH
		|=> s_r.ctl[$past(wr_sel)].mode == tct_pkg::decode_mode($past(cw)))
		else $error("Mode field decoded wrongly");

	a_format_kept: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel != tct_pkg::SEL_ILLEGAL && wr_fmt != tct_pkg::FMT_LATCH
		|=> s_r.ch[$past(wr_sel)].fmt == $past(wr_fmt) &&
		!s_r.ch[$past(wr_sel)].wr_high_next)
		else $error("Access format not stored");

	a_latch_capture: assert property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel != tct_pkg::SEL_ILLEGAL && wr_fmt == tct_pkg::FMT_LATCH &&
		!s_r.ch[wr_sel].latched
		|=> s_r.ch[$past(wr_sel)].latched &&
		s_r.ch[$past(wr_sel)].latch_val == $past(latch_src))
		else $error("Latch command missed the count");

	// One check a channel; a copy may sit unread for long
	for (genvar q = 0; q < tct_pkg::NUM_CNT; q++) begin : g_latch_chk
		a_latch_stable: assert property (
			s_r.ch[q].latched && $past(s_r.ch[q].latched)
			|-> $stable(s_r.ch[q].latch_val))
			else $error("Latched copy moved");
	end

	a_low_byte_first: assert property (
		wr_done && wr_idx != tct_pkg::OFS_CTRL &&
		s_r.ch[wr_idx].fmt == tct_pkg::FMT_BOTH &&
		!s_r.ch[wr_idx].wr_high_next
		|=> load_vec == '0 ##0 s_r.ch[$past(wr_idx)].wr_high_next)
		else $error("Low byte did not wait for the high byte");

	a_read_low_first: assert property (
		rd_start && rd_idx != tct_pkg::OFS_CTRL &&
		s_r.ch[rd_idx].fmt == tct_pkg::FMT_BOTH &&
		!s_r.ch[rd_idx].rd_high_next
		|=> data_out == $past(rd_lo) &&
		s_r.ch[$past(rd_idx)].rd_high_next)
		else $error("Two byte read did not start with the low byte");

	a_unselected_quiet: assert property (
		s_r.sync.wr_n && !s_r.prev.wr_n && s_r.prev.cs_n
		|=> arm_vec == '0 && load_vec == '0)
		else $error("Unselected write reached a counter");

	a_oe_selected: assert property (
		data_oe |-> !$past(s_r.sync.cs_n))
		else $error("Data driven while not selected");

	a_oe_ctrl_port: assert property (
		data_oe |-> $past(s_r.sync.addr) != tct_pkg::OFS_CTRL)
		else $error("Data driven for the control port");

	a_irq_paths: assert property (
		$past(resetn) |-> irq_high == !$past(s_r.sync.sixth) &&
		irq_low == ($past(s_r.sync.twelfth) || $past(s_r.sync.ext_irq)))
		else $error("Interrupt request pins wrong");

	c_latch_cmd: cover property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_fmt == tct_pkg::FMT_LATCH && wr_sel != tct_pkg::SEL_ILLEGAL);
	c_both_load: cover property (
		wr_done && wr_idx != tct_pkg::OFS_CTRL &&
		s_r.ch[wr_idx].fmt == tct_pkg::FMT_BOTH && s_r.ch[wr_idx].wr_high_next);
	c_illegal_word: cover property (
		wr_done && wr_idx == tct_pkg::OFS_CTRL &&
		wr_sel == tct_pkg::SEL_ILLEGAL);
	c_read_latched: cover property (
		rd_start && rd_idx != tct_pkg::OFS_CTRL && s_r.ch[rd_idx].latched);
	c_unselected_write: cover property (
		s_r.sync.wr_n && !s_r.prev.wr_n && s_r.prev.cs_n);

endmodule : triple_counter_timer_port

/* tb/host_model.sv */
// Host processor model driving the byte wide port of the counter block
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic core_clk,
	// Byte port toward the block
	output logic chip_sel_n,
	output logic read_n,
	output logic write_n,
	output logic [1:0] port_addr,
	output logic [tct_pkg::BYTE_W-1:0] data_in,
	input wire logic [tct_pkg::BYTE_W-1:0] data_out,
	input wire logic data_oe
);
	initial begin
		chip_sel_n = 1'b1;
		read_n = 1'b1;
		write_n = 1'b1;
		port_addr = 2'h0;
		data_in = 8'h00;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle

	// Qualifiers outlive the strobe; block takes writes at strobe end
	task automatic wr(input logic [1:0] a, input logic [7:0] d,
		input logic sel_n);
		@(posedge core_clk);
		chip_sel_n <= sel_n;
		port_addr <= a;
		data_in <= d;
		write_n <= 1'b0;
		idle(4);
		write_n <= 1'b1;
		idle(4);
		chip_sel_n <= 1'b1;
		// Released bus must not keep showing the last byte
		data_in <= ~d;
		idle(4);
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d,
		output logic oe);
		@(posedge core_clk);
		chip_sel_n <= 1'b0;
		port_addr <= a;
		read_n <= 1'b0;
		idle(5);
		d = data_out;
		oe = data_oe;
		read_n <= 1'b1;
		idle(4);
		chip_sel_n <= 1'b1;
		idle(4);
	endtask : rd
endmodule : host_model

/* tb/triple_counter_timer_port_tb.sv */
// Self-checking bench of the three counter timer block
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module triple_counter_timer_port_tb;
	logic core_clk;
	logic resetn;
	logic chip_sel_n;
	logic read_n;
	logic write_n;
	logic [1:0] port_addr;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe;
	logic [2:0] count_clk;
	logic [2:0] count_gate;
	logic [2:0] count_out;
	logic sixth;
	logic twelfth;
	logic ext_irq;
	logic irq_high;
	logic irq_low;
	logic [7:0] rd_b;
	logic rd_oe;
	int error_cnt;
	int num_checks;

	host_model host_model_i (.core_clk(core_clk), .chip_sel_n(chip_sel_n),
		.read_n(read_n), .write_n(write_n), .port_addr(port_addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	triple_counter_timer_port triple_counter_timer_port_i (
		.core_clk(core_clk), .resetn(resetn), .chip_sel_n(chip_sel_n),
		.read_n(read_n), .write_n(write_n), .port_addr(port_addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.count_clk(count_clk), .count_gate(count_gate),
		.count_out(count_out), .sixth_counter_output(sixth),
		.twelfth_counter_output(twelfth), .ext_irq_in(ext_irq),
		.irq_high(irq_high), .irq_low(irq_low));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	// One counting clock, high for 3 and low for 6 core clocks, stays under 5 MHz
	task automatic pulse(input int ch);
		@(posedge core_clk);
		count_clk[ch] <= 1'b1;
		host_model_i.idle(3);
		count_clk[ch] <= 1'b0;
		host_model_i.idle(6);
	endtask : pulse

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		host_model_i.rd(a, rd_b, rd_oe);
		`CHK(rd_b, exp)
		`CHK(rd_oe, 1'b1)
	endtask : rd_chk

	task automatic t_load_read();
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h30, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT0, 8'h34, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT0, 8'h12, 1'b0);
		rd_chk(tct_pkg::OFS_CNT0, 8'h34);
		rd_chk(tct_pkg::OFS_CNT0, 8'h12);
		host_model_i.rd(tct_pkg::OFS_CTRL, rd_b, rd_oe);
		`CHK(rd_oe, 1'b0)
		$display("t_load_read done");
	endtask : t_load_read

	task automatic t_count_latch();
		count_gate[1] <= 1'b1;
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h70, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT1, 8'h02, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT1, 8'h00, 1'b0);
		`CHK(count_out[1], 1'b0)
		pulse(1);
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h40, 1'b0);
		// Counting goes on behind the frozen copy
		pulse(1);
		rd_chk(tct_pkg::OFS_CNT1, 8'h01);
		rd_chk(tct_pkg::OFS_CNT1, 8'h00);
		`CHK(count_out[1], 1'b1)
		pulse(1);
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h40, 1'b0);
		rd_chk(tct_pkg::OFS_CNT1, 8'hff);
		rd_chk(tct_pkg::OFS_CNT1, 8'hff);
		$display("t_count_latch done");
	endtask : t_count_latch

	task automatic t_illegal();
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'hf0, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h10, 1'b1);
		rd_chk(tct_pkg::OFS_CNT0, 8'h34);
		rd_chk(tct_pkg::OFS_CNT0, 8'h12);
		$display("t_illegal done");
	endtask : t_illegal

	task automatic t_bcd_formats();
		count_gate[2] <= 1'b1;
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'hb1, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT2, 8'h00, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT2, 8'h00, 1'b0);
		pulse(2);
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h80, 1'b0);
		rd_chk(tct_pkg::OFS_CNT2, 8'h99);
		rd_chk(tct_pkg::OFS_CNT2, 8'h99);
		count_gate[2] <= 1'b0;
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h90, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT2, 8'h05, 1'b0);
		// Gate is low, so this clock must leave the count alone
		pulse(2);
		rd_chk(tct_pkg::OFS_CNT2, 8'h05);
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'ha0, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT2, 8'h03, 1'b0);
		rd_chk(tct_pkg::OFS_CNT2, 8'h03);
		$display("t_bcd_formats done");
	endtask : t_bcd_formats

	// Arming drives the output low in mode 0 only
	task automatic t_modes();
		for (int m = 0; m < 8; m++) begin
			host_model_i.wr(tct_pkg::OFS_CTRL, {4'h3, m[2:0], 1'b0}, 1'b0);
			`CHK(count_out[0], (m != 0))
		end
		$display("t_modes done");
	endtask : t_modes

	// Rate mode: output dips for the count of one, then reloads
	task automatic t_rate();
		host_model_i.wr(tct_pkg::OFS_CTRL, 8'h54, 1'b0);
		host_model_i.wr(tct_pkg::OFS_CNT1, 8'h03, 1'b0);
		`CHK(count_out[1], 1'b1)
		pulse(1);
		pulse(1);
		`CHK(count_out[1], 1'b0)
		pulse(1);
		`CHK(count_out[1], 1'b1)
		rd_chk(tct_pkg::OFS_CNT1, 8'h03);
		$display("t_rate done");
	endtask : t_rate

	task automatic t_irq();
		logic [2:0] v;
		for (int i = 0; i < 8; i++) begin
			v = i[2:0];
			sixth <= v[0];
			twelfth <= v[1];
			ext_irq <= v[2];
			host_model_i.idle(6);
			`CHK(irq_high, ~v[0])
			`CHK(irq_low, v[1] | v[2])
		end
		$display("t_irq done");
	endtask : t_irq

	initial begin
		error_cnt = 0;
		num_checks = 0;
		resetn = 1'b0;
		count_clk = 3'b000;
		count_gate = 3'b000;
		sixth = 1'b1;
		twelfth = 1'b0;
		ext_irq = 1'b0;
		host_model_i.idle(8);
		resetn <= 1'b1;
		host_model_i.idle(2);
		t_load_read();
		t_count_latch();
		t_illegal();
		t_bcd_formats();
		t_modes();
		t_rate();
		t_irq();
		summarize();
	end

	// Tests need well under 5000 core clocks
	initial begin
		#1_000_000;
		error_cnt++;
		summarize();
	end
endmodule : triple_counter_timer_port_tb
